/* File: inc/t2cu_pkg.sv */
package t2cu_pkg;
    // counter geometry and mode codes
    localparam int unsigned CNT_W       = 8;
    localparam logic [7:0]  CNT_BOTTOM  = 8'h00;
    localparam logic [7:0]  CNT_MAX     = 8'hff;
    localparam logic [7:0]  CNT_RESET   = 8'h00;
    localparam logic [7:0]  CMP_RESET   = 8'h00;
    // wave mode select encodings
    localparam logic [1:0]  WM_NORMAL   = 2'h0;
    localparam logic [1:0]  WM_PC_PWM   = 2'h1;
    localparam logic [1:0]  WM_CTC      = 2'h2;
    localparam logic [1:0]  WM_FAST_PWM = 2'h3;
    // tick source select encodings
    localparam logic [2:0]  TS_STOP     = 3'h0;
    localparam logic [2:0]  TS_DIV1     = 3'h1;
    localparam logic [2:0]  TS_DIV8     = 3'h2;
    localparam logic [2:0]  TS_DIV32    = 3'h3;
    localparam logic [2:0]  TS_DIV64    = 3'h4;
    localparam logic [2:0]  TS_DIV128   = 3'h5;
    localparam logic [2:0]  TS_DIV256   = 3'h6;
    localparam logic [2:0]  TS_EXT      = 3'h7;
    // prescaler width covers the largest division
    localparam int unsigned PRE_W       = 10;
    localparam logic [9:0]  PRE_DIV1024 = 10'h3ff;

    // cpu write strobes with their data
    typedef struct packed {
        logic       cnt_we;
        logic [7:0] cnt_wdata;
        logic       cmp_we;
        logic [7:0] cmp_wdata;
        logic       ocf_clr;
    } t2cu_cpu_wr_t;

    // control settings from the timer control register
    typedef struct packed {
        logic [2:0] tick_source_select;
        logic [1:0] wave_mode_select;
        logic       compare_irq_enable;
        logic       ovf_irq_enable;
    } t2cu_ctrl_t;

    typedef enum logic [1:0] {
        T2CU_CLEAR,
        T2CU_INC,
        T2CU_DEC,
        T2CU_HOLD
    } t2cu_action_t;
endpackage : t2cu_pkg

/* File: core/t2cu_tick_gen.sv */
module t2cu_tick_gen
    import t2cu_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    // selection and external clock pin
    input  wire logic [2:0] i_sel,
    input  wire logic       i_ext_pin,
    // one-cycle tick enable
    output logic            o_tick
);
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [2:0]       sync_reg, sync_next;
    logic             prev_reg, prev_next;
    logic             tick_reg, tick_next;
    logic             ext_lvl;

    // a level counts only when the second and third stages agree
    assign ext_lvl = sync_reg[2];

    // prescaler taps and external edge detect
    always_comb begin
        pre_next  = pre_reg + 10'h001;
        sync_next = {sync_reg[1:0], i_ext_pin};
        prev_next = (sync_reg[1] == sync_reg[2]) ? ext_lvl : prev_reg;
        unique case (i_sel)
            TS_STOP:   tick_next = 1'b0;
            TS_DIV1:   tick_next = 1'b1;
            TS_DIV8:   tick_next = (pre_reg[2:0] == 3'h7);
            TS_DIV32:  tick_next = (pre_reg[4:0] == 5'h1f);
            TS_DIV64:  tick_next = (pre_reg[5:0] == 6'h3f);
            TS_DIV128: tick_next = (pre_reg[6:0] == 7'h7f);
            TS_DIV256: tick_next = (pre_reg[7:0] == 8'hff);
            TS_EXT:    tick_next = (sync_reg[1] == sync_reg[2])
                                   && ext_lvl && !prev_reg;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_reg  <= '0;
            sync_reg <= 3'h0;
            prev_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            sync_reg <= sync_next;
            prev_reg <= prev_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick = tick_reg;
endmodule : t2cu_tick_gen

/* File: core/t2cu_counter.sv */
// How it works
// - clear action forces every count bit to zero
// - top output high while count equals maximum
// - bottom output high while count equals zero
// - each tick clears, increments or decrements per mode
// - tick comes from internal prescaler or external pin
// - tick source zero gives no ticks; count stops
// - cpu may read and write count at any time
// - cpu count write beats a coincident clear or count
// - two wave mode select bits choose the count sequence
// - overflow flag set where the mode defines overflow
// - overflow flag offered as an interrupt request
// - compare output waveform follows the mode's counting
// - eight-bit comparator flags count equal to compare value
// - match sets compare flag next tick; irq if enabled
// - compare flag cleared on irq acknowledge or written one
module t2cu_counter
    import t2cu_pkg::*;
(
    // clock and reset
    input  wire logic         I_CLK,
    input  wire logic         I_RSTN,
    // cpu side
    input  wire t2cu_cpu_wr_t I_CPU_WR,
    input  wire t2cu_ctrl_t   I_CTRL,
    input  wire logic         I_OVF_FLAG_CLR,
    input  wire logic         I_OVF_IRQ_ACK,
    input  wire logic         I_CMP_IRQ_ACK,
    // external tick pin
    input  wire logic         I_EXT_TICK_PIN,
    // count and status
    output logic [7:0]        O_TIMER_COUNT,
    output logic [7:0]        O_COMPARE_VALUE,
    output logic              O_TOP,
    output logic              O_BOTTOM,
    output logic              O_MATCH,
    output logic              O_OVERFLOW_FLAG,
    output logic              O_COMPARE_MATCH_FLAG,
    output logic              O_OVF_IRQ,
    output logic              O_CMP_IRQ,
    // compare output pin
    output logic              O_COMPARE_OUTPUT_PIN
);
    import t2cu_pkg::*;

    // state and next-value pairs, one pair per register
    logic         tick;
    logic [7:0]   cnt_reg, cnt_next;
    logic [7:0]   cmp_reg, cmp_next;
    logic         down_reg, down_next;
    logic         tov_reg, tov_next;
    logic         ocf_reg, ocf_next;
    logic         oc_reg, oc_next;
    logic         top_reg, top_next;
    logic         bot_reg, bot_next;
    logic         match_reg, match_next;
    logic         ovf_irq_reg, ovf_irq_next;
    logic         cmp_irq_reg, cmp_irq_next;
    t2cu_action_t action;
    logic         ovf_evt;
    logic         match_now;

    // top of the count: compare value in clear-on-match, else the maximum
    function automatic logic [7:0] mode_top(input logic [1:0] wm,
                                            input logic [7:0] cmp);
        mode_top = (wm == WM_CTC) ? cmp : CNT_MAX;
    endfunction : mode_top

    // extreme-value decodes, shared by the action, flag and status paths
    function automatic logic cnt_is_max(input logic [7:0] v);
        cnt_is_max = (v == CNT_MAX);
    endfunction : cnt_is_max

    function automatic logic cnt_is_bottom(input logic [7:0] v);
        cnt_is_bottom = (v == CNT_BOTTOM);
    endfunction : cnt_is_bottom

    // tick source, stopped when the select field is zero
    // the divider registers its tick, so a new select acts two edges later
    t2cu_tick_gen u_tick (
        .i_clk     (I_CLK),
        .i_rstn    (I_RSTN),
        .i_sel     (I_CTRL.tick_source_select),
        .i_ext_pin (I_EXT_TICK_PIN),
        .o_tick    (tick)
    );

    // comparator runs every cycle, not only on ticks
    // one match wire feeds flag, clear and pin, so all three agree
    assign match_now = (cnt_reg == cmp_reg);

    // action chosen per mode on each tick
    always_comb begin
        action  = T2CU_HOLD;
        ovf_evt = 1'b0;
        if (tick) begin
            unique case (I_CTRL.wave_mode_select)
                WM_NORMAL, WM_FAST_PWM: begin
                    // overflow is the wrap out of the maximum
                    action  = T2CU_INC;
                    ovf_evt = cnt_is_max(cnt_reg);
                end
                WM_CTC: begin
                    // compare at the maximum: clear and overflow coincide
                    action  = match_now ? T2CU_CLEAR : T2CU_INC;
                    ovf_evt = cnt_is_max(cnt_reg);
                end
                WM_PC_PWM: begin
                    // overflow marks the turn at the bottom
                    action  = down_reg ? T2CU_DEC : T2CU_INC;
                    ovf_evt = down_reg && (cnt_reg == 8'h01);
                end
            endcase
        end
    end

    // count path: cpu write has priority over every tick action
    // a tick that meets a write is lost, and so is its overflow
    always_comb begin
        cnt_next  = cnt_reg;
        down_next = down_reg;
        if (I_CPU_WR.cnt_we) begin
            cnt_next = I_CPU_WR.cnt_wdata;
        end else begin
            unique case (action)
                T2CU_CLEAR: cnt_next = CNT_BOTTOM;
                T2CU_INC:   cnt_next = cnt_reg + 8'h01;
                T2CU_DEC:   cnt_next = cnt_reg - 8'h01;
                T2CU_HOLD:  cnt_next = cnt_reg;
            endcase
        end
        // dual slope turns at the extremes
        // limitation: a count written at the maximum while rising wraps
        if (I_CTRL.wave_mode_select != WM_PC_PWM) begin
            down_next = 1'b0;
        end else if (tick && !I_CPU_WR.cnt_we) begin
            if (!down_reg && cnt_reg == 8'hfe) down_next = 1'b1;
            else if (down_reg && cnt_reg == 8'h01) down_next = 1'b0;
        end
        cmp_next = I_CPU_WR.cmp_we ? I_CPU_WR.cmp_wdata : cmp_reg;
    end

    // flags: a hardware set wins over a clear in the same cycle
    always_comb begin
        tov_next = tov_reg;
        if (I_OVF_FLAG_CLR || I_OVF_IRQ_ACK) tov_next = 1'b0;
        if (ovf_evt && !I_CPU_WR.cnt_we) tov_next = 1'b1;
        // compare flag, same priority
        ocf_next = ocf_reg;
        if (I_CPU_WR.ocf_clr || I_CMP_IRQ_ACK) ocf_next = 1'b0;
        if (tick && match_now) ocf_next = 1'b1;
        // irq copies follow the next flag values, so they rise together
        ovf_irq_next = tov_next && I_CTRL.ovf_irq_enable;
        cmp_irq_next = ocf_next && I_CTRL.compare_irq_enable;
        // status uses next values so it lines up with the count
        top_next     = cnt_is_max(cnt_next);
        bot_next     = cnt_is_bottom(cnt_next);
        match_next   = (cnt_next == cmp_next);
    end

    // waveform on the compare output pin
    // the pin sees the old count, just as the compare flag does
    always_comb begin
        oc_next = oc_reg;
        if (tick && !I_CPU_WR.cnt_we) begin
            unique case (I_CTRL.wave_mode_select)
                WM_NORMAL, WM_CTC: begin
                    if (match_now) oc_next = !oc_reg;         // toggle on match
                end
                WM_FAST_PWM: begin
                    if (match_now) oc_next = 1'b0;
                    else if (cnt_reg == mode_top(I_CTRL.wave_mode_select,
                                                 cmp_reg))
                        oc_next = 1'b1;                       // set at top wrap
                end
                WM_PC_PWM: begin
                    if (match_now) oc_next = down_reg;        // up clears, down sets
                end
            endcase
        end
    end

    // state registers; outputs come straight from these
    // reset values agree with a zero count and a zero compare value
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cnt_reg     <= CNT_RESET;
            cmp_reg     <= CMP_RESET;
            down_reg    <= 1'b0;
            tov_reg     <= 1'b0;
            ocf_reg     <= 1'b0;
            oc_reg      <= 1'b0;
            top_reg     <= 1'b0;
            bot_reg     <= 1'b1;
            match_reg   <= 1'b1;
            ovf_irq_reg <= 1'b0;
            cmp_irq_reg <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            cmp_reg     <= cmp_next;
            down_reg    <= down_next;
            tov_reg     <= tov_next;
            ocf_reg     <= ocf_next;
            oc_reg      <= oc_next;
            top_reg     <= top_next;
            bot_reg     <= bot_next;
            match_reg   <= match_next;
            ovf_irq_reg <= ovf_irq_next;
            cmp_irq_reg <= cmp_irq_next;
        end
    end

    // every output is a plain register copy
    assign O_TIMER_COUNT        = cnt_reg;
    assign O_COMPARE_VALUE      = cmp_reg;
    assign O_TOP                = top_reg;
    assign O_BOTTOM             = bot_reg;
    assign O_MATCH              = match_reg;
    assign O_OVERFLOW_FLAG      = tov_reg;
    assign O_COMPARE_MATCH_FLAG = ocf_reg;
    assign O_OVF_IRQ            = ovf_irq_reg;
    assign O_CMP_IRQ            = cmp_irq_reg;
    assign O_COMPARE_OUTPUT_PIN = oc_reg;
endmodule : t2cu_counter

/* File: dv/t2cu_counter_sva.sv */
module t2cu_counter_sva
    import t2cu_pkg::*;
(
    // clock and reset
    input wire logic         I_CLK,
    input wire logic         I_RSTN,
    // watched inputs
    input wire t2cu_cpu_wr_t I_CPU_WR,
    input wire t2cu_ctrl_t   I_CTRL,
    // watched outputs
    input wire logic [7:0]   O_TIMER_COUNT,
    input wire logic         O_TOP,
    input wire logic         O_BOTTOM,
    input wire logic         O_MATCH,
    input wire logic         O_OVERFLOW_FLAG,
    input wire logic         O_COMPARE_MATCH_FLAG,
    input wire logic         O_CMP_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // a normal-mode cycle with no cpu write in it
    logic nrm;
    assign nrm = I_CTRL.wave_mode_select == WM_NORMAL && !I_CPU_WR.cnt_we;
    property p_top; O_TOP == (O_TIMER_COUNT == CNT_MAX); endproperty
    a_top: assert property (p_top) else $error("top wrong");
    property p_bot; O_BOTTOM == (O_TIMER_COUNT == CNT_BOTTOM); endproperty
    a_bot: assert property (p_bot) else $error("bottom wrong");
    property p_write; I_CPU_WR.cnt_we |=>
        O_TIMER_COUNT == $past(I_CPU_WR.cnt_wdata); endproperty
    a_write: assert property (p_write) else $error("write lost");
    // the tick path is registered, so wait out its pipeline first
    property p_stop; (I_CTRL.tick_source_select == TS_STOP) [*6]
        ##0 !I_CPU_WR.cnt_we |=> $stable(O_TIMER_COUNT); endproperty
    a_stop: assert property (p_stop) else $error("count moved");
    property p_inc; nrm ##1 $changed(O_TIMER_COUNT) |->
        O_TIMER_COUNT == $past(O_TIMER_COUNT) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("bad step");
    property p_wrap; nrm && O_TIMER_COUNT == CNT_MAX ##1
        O_TIMER_COUNT == CNT_BOTTOM |-> O_OVERFLOW_FLAG; endproperty
    a_wrap: assert property (p_wrap) else $error("no overflow");
    property p_cmpf; $rose(O_COMPARE_MATCH_FLAG) |->
        $past(O_MATCH) || $past(O_MATCH, 2); endproperty
    a_cmpf: assert property (p_cmpf) else $error("stray flag");
    property p_irq; (O_COMPARE_MATCH_FLAG && I_CTRL.compare_irq_enable)
        [*2] |-> O_CMP_IRQ; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
endmodule : t2cu_counter_sva

/* File: dv/t2cu_cpu_model.sv */
module t2cu_cpu_model (
    // clock, reset and answer speed
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_slow,
    // interrupt requests and their acknowledges
    input  wire logic i_ovf_irq,
    input  wire logic i_cmp_irq,
    output logic      o_ovf_ack,
    output logic      o_cmp_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] irq_vec;
    logic [1:0] ack_reg;
    logic [3:0] wait_reg [2];
    assign irq_vec = {i_cmp_irq, i_ovf_irq};
    assign o_ovf_ack = ack_reg[0];
    assign o_cmp_ack = ack_reg[1];
    // serve a request after a latency; the count restarts on service
    // so a request still high while the flag clears is not served twice
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wait_reg <= '{default: 4'h0};
            ack_reg  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                ack_reg[i]  <= irq_vec[i] &&
                    wait_reg[i] == (i_slow ? 4'hc : 4'h3);
                wait_reg[i] <= (irq_vec[i] && !ack_reg[i]) ?
                    wait_reg[i] + 4'h1 : 4'h0;
            end
        end
    end
endmodule : t2cu_cpu_model

/* File: dv/t2cu_counter_tb.sv */
bind t2cu_counter t2cu_counter_sva u_sva (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CPU_WR(I_CPU_WR), .I_CTRL(I_CTRL),
    .O_TIMER_COUNT(O_TIMER_COUNT), .O_TOP(O_TOP), .O_BOTTOM(O_BOTTOM),
    .O_MATCH(O_MATCH), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
    .O_COMPARE_MATCH_FLAG(O_COMPARE_MATCH_FLAG), .O_CMP_IRQ(O_CMP_IRQ)
);
module t2cu_counter_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import t2cu_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ext = 1'b0, slow = 1'b0, ovf_clr = 1'b0;
    logic ovf_ack, cmp_ack, ovf_irq, cmp_irq, top, bot, mat, ovf, cmpf, pin;
    logic p0;
    logic [7:0] cnt, cmpv, a;
    t2cu_cpu_wr_t wr = '0;
    t2cu_ctrl_t ctl = '0;
    int err_total = 0, n_checks = 0, n;
    always #12.5 clk = ~clk;
    t2cu_counter DUT (
        .I_CLK(clk), .I_RSTN(rstn), .I_CPU_WR(wr), .I_CTRL(ctl),
        .I_OVF_FLAG_CLR(ovf_clr), .I_OVF_IRQ_ACK(ovf_ack),
        .I_CMP_IRQ_ACK(cmp_ack), .I_EXT_TICK_PIN(ext),
        .O_TIMER_COUNT(cnt), .O_COMPARE_VALUE(cmpv), .O_TOP(top),
        .O_BOTTOM(bot), .O_MATCH(mat), .O_OVERFLOW_FLAG(ovf),
        .O_COMPARE_MATCH_FLAG(cmpf), .O_OVF_IRQ(ovf_irq),
        .O_CMP_IRQ(cmp_irq), .O_COMPARE_OUTPUT_PIN(pin));
    t2cu_cpu_model u_cpu (.i_clk(clk), .i_rstn(rstn), .i_slow(slow),
        .i_ovf_irq(ovf_irq), .i_cmp_irq(cmp_irq), .o_ovf_ack(ovf_ack),
        .o_cmp_ack(cmp_ack));
    // compare one result, flags are widened to a byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // cpu access: 0 count, 1 compare, 2 compare flag, 3 overflow flag
    task automatic cpu_wr(input int k, input logic [7:0] v);
        @(posedge clk);
        wr <= '{k == 0, v, k == 1, v, k == 2};
        ovf_clr <= (k == 3);
        @(posedge clk);
        wr <= '0;
        ovf_clr <= 1'b0;
        @(negedge clk);
    endtask : cpu_wr
    task automatic set_ctl(input t2cu_ctrl_t c);
        @(posedge clk);
        ctl <= c;
        @(negedge clk);
    endtask : set_ctl
    function automatic logic probe(input int k);
        if (k == 0) return ovf;
        if (k == 1) return cmpf;
        return cnt !== a;
    endfunction : probe
    // bounded wait, n keeps the cycles spent
    task automatic wait_on(input int k, input logic v);
        n = 0;
        while (probe(k) !== v && n < 600) begin
            @(negedge clk);
            n++;
        end
        // a wait that runs out is a failure in its own right
        if (probe(k) !== v) begin
            err_total++;
            $display("MISMATCH t=%0t wait %0d got=%h exp=%h",
                     $time, k, probe(k), v);
        end
    endtask : wait_on
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // hangs are cut well past the expected thousand or so cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({7'h0, bot}, 8'h01);
        chk({7'h0, mat}, 8'h01);
        cpu_wr(0, 8'h55);
        repeat (20) @(negedge clk);
        chk(cnt, 8'h55);
        cpu_wr(0, CNT_MAX);
        chk({7'h0, top}, 8'h01);
        set_ctl('{TS_DIV1, WM_NORMAL, 1'b0, 1'b0});
        wait_on(0, 1'b1);
        chk({7'h0, ovf}, 8'h01);
        a = cnt;
        @(negedge clk);
        chk(cnt, a + 8'h01);
        slow = 1'b1;
        set_ctl('{TS_DIV1, WM_NORMAL, 1'b1, 1'b1});
        @(negedge clk);
        chk({7'h0, ovf_irq}, 8'h01);
        wait_on(0, 1'b0);
        chk({7'h0, ovf}, 8'h00);
        chk({7'h0, ovf_irq}, 8'h00);
        slow = 1'b0;
        set_ctl('{TS_DIV1, WM_NORMAL, 1'b1, 1'b0});
        cpu_wr(0, 8'h10);
        chk(cnt, 8'h10);
        cpu_wr(1, 8'h30);
        chk(cmpv, 8'h30);
        p0 = pin;
        wait_on(1, 1'b1);
        chk({7'h0, cmpf}, 8'h01);
        chk({7'h0, pin}, {7'h0, ~p0});
        wait_on(1, 1'b0);
        chk({7'h0, cmpf}, 8'h00);
        set_ctl('{TS_DIV1, WM_NORMAL, 1'b0, 1'b0});
        wait_on(1, 1'b1);
        cpu_wr(2, 8'h00);
        chk({7'h0, cmpf}, 8'h00);
        chk({7'h0, ovf}, 8'h01);
        cpu_wr(3, 8'h00);
        chk({7'h0, ovf}, 8'h00);
        set_ctl('{TS_DIV1, WM_CTC, 1'b0, 1'b0});
        cpu_wr(1, 8'h05);
        cpu_wr(0, 8'h00);
        a = 8'h00;
        repeat (20) begin
            @(negedge clk);
            if (cnt > a) a = cnt;
        end
        chk(a, 8'h05);
        set_ctl('{TS_DIV1, WM_PC_PWM, 1'b0, 1'b0});
        cpu_wr(0, 8'hfd);
        repeat (8) @(negedge clk);
        a = cnt;
        @(negedge clk);
        chk(cnt, a - 8'h01);
        wait_on(0, 1'b1);
        chk(cnt, CNT_BOTTOM);
        set_ctl('{TS_DIV8, WM_NORMAL, 1'b0, 1'b0});
        // first change is the last divide-by-one tick, the second aligns
        // to the divider, the third is a full divider period
        a = cnt;
        wait_on(2, 1'b1);
        a = cnt;
        wait_on(2, 1'b1);
        a = cnt;
        wait_on(2, 1'b1);
        chk(n[7:0], 8'h08);
        set_ctl('{TS_EXT, WM_NORMAL, 1'b0, 1'b0});
        cpu_wr(0, 8'h00);
        repeat (3) begin
            @(posedge clk);
            ext <= 1'b1;
            repeat (5) @(posedge clk);
            ext <= 1'b0;
            repeat (5) @(negedge clk);
        end
        repeat (8) @(negedge clk);
        chk(cnt, 8'h03);
        // fast pwm: pin set at the wrap, cleared at the match
        cpu_wr(3, 8'h00);
        set_ctl('{TS_DIV1, WM_FAST_PWM, 1'b0, 1'b0});
        cpu_wr(1, 8'h40);
        wait_on(0, 1'b1);
        chk(cnt, CNT_BOTTOM);
        chk({7'h0, pin}, 8'h01);
        repeat (70) @(negedge clk);
        chk({7'h0, pin}, 8'h00);
        summarize();
    end
endmodule : t2cu_counter_tb
